//--- spp_pkg.sv
package spp_pkg;
    // timing counts in internal clock cycles; on-period delays from switch turn-on, off-time from turn-off
    localparam logic [9:0] SPP_LOW_SAMPLE_CYC = 10'h013;   // low-current flag sample point
    localparam logic [9:0] SPP_BLANK_CYC = 10'h004;        // high-current flag blanking
    localparam logic [9:0] SPP_FOLDBACK_CYC = 10'h01a;     // foldback delay, end of high-flag window
    localparam logic [9:0] SPP_FORCE_ON_CYC = 10'h008;     // force-on pulse length
    localparam logic [9:0] SPP_MIN_ON_CYC = 10'h004;       // shortest on-time step floor
    localparam logic [9:0] SPP_MAX_OFF_CYC = 10'h1ea;      // longest off-time (490 cycles)
    localparam logic [9:0] SPP_DEFAULT_RES_CYC = 10'h03d;  // resonance before first measure
    localparam logic [9:0] SPP_STEP_CYC = 10'h002;         // duty adjust step
    localparam logic [2:0] SPP_DESAT_LIMIT = 3'h4;         // consecutive desat cycles
    localparam logic [7:0] SPP_FOLDBACK_CYCLES = 8'h40;    // cycles spent in foldback
    localparam logic [7:0] SPP_BURST_CYCLES = 8'h10;       // cycles spent in power burst
    localparam logic [3:0] SPP_PBD_MAX = 4'hf;             // top proportional drive level
    // status bit positions
    localparam int SPP_EV_OVERLOAD = 0;
    localparam int SPP_EV_FOLDBACK = 1;
    localparam int SPP_EV_THERMAL = 2;
    localparam int SPP_EV_SLEEP = 3;

    typedef enum logic [2:0] {
        SPP_M_STANDBY, SPP_M_NORMAL, SPP_M_OVERLOAD, SPP_M_FOLDBACK, SPP_M_BURST
    } spp_mode_t;

    typedef enum logic [1:0] {SPP_S_SLEEP, SPP_S_ACTIVE} spp_supply_t;

    // raw analog comparator flags, all asynchronous to sys_clk
    typedef struct packed {
        logic low_current_flag;
        logic high_current_flag;
        logic collector_desat_guard;
        logic collector_above_ref;
        logic over_temperature;
        logic temp_cleared;
        logic undervolt;
        logic wake;
        logic resonance_edge;
    } spp_sense_t;

    // base-drive pin group
    typedef struct packed {
        logic base_drive_out;
        logic force_on_pulse;
        logic proportional_drive_phase;
        logic [3:0] pbd_level;
    } spp_drive_t;
endpackage

//--- spp_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for the comparator flag bundle
module spp_sync
    import spp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // flags
    input wire spp_sense_t raw,
    output spp_sense_t synced
);
    typedef struct packed {
        spp_sense_t meta;
        spp_sense_t sync;
    } spp_sync_state_t;

    spp_sync_state_t st_q; // both stages
    spp_sync_state_t st_d; // next value

    // first stage only feeds the second
    always_comb begin
        st_d.meta = raw;
        st_d.sync = st_q.meta;
    end

    // register both stages
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign synced = st_q.sync;
endmodule

//--- spp_regs.sv
`timescale 1ns/1ps
// register file: offsets, sticky status with write-one-clear, mask, irq
module spp_regs
    import spp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // block side
    input wire logic [3:0] events,
    input wire logic [31:0] state_word,
    output logic drive_enable,
    output logic irq
);
    localparam logic [3:0] SPP_OFF_CTRL = 4'h0;
    localparam logic [3:0] SPP_OFF_STATE = 4'h4;
    localparam logic [3:0] SPP_OFF_STATUS = 4'h8;
    localparam logic [3:0] SPP_OFF_MASK = 4'hc;

    typedef struct packed {
        logic ctrl_en;
        logic [3:0] status;
        logic [3:0] mask;
        logic [31:0] rdata;
    } spp_reg_state_t;

    spp_reg_state_t st_q; // registers
    spp_reg_state_t st_d; // next value

    // decode, write-one-clear with set winning, read mux
    always_comb begin
        st_d = st_q;
        st_d.rdata = '0;
        if (reg_wr && reg_addr == SPP_OFF_CTRL) begin
            st_d.ctrl_en = reg_wdata[0];
        end
        if (reg_wr && reg_addr == SPP_OFF_MASK) begin
            st_d.mask = reg_wdata[3:0];
        end
        // clear first so a same-cycle event survives
        if (reg_wr && reg_addr == SPP_OFF_STATUS) begin
            st_d.status = st_q.status & ~reg_wdata[3:0];
        end
        st_d.status = st_d.status | events;
        if (reg_rd) begin
            unique case (reg_addr)
                SPP_OFF_CTRL: st_d.rdata = {31'h0, st_q.ctrl_en};
                SPP_OFF_STATE: st_d.rdata = state_word;
                SPP_OFF_STATUS: st_d.rdata = {28'h0, st_q.status};
                SPP_OFF_MASK: st_d.rdata = {28'h0, st_q.mask};
                default: st_d.rdata = '0; // unmapped reads zero
            endcase
        end
    end

    // register update
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '{ctrl_en: 1'b1, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign drive_enable = st_q.ctrl_en;
    assign irq = |(st_q.status & st_q.mask);
endmodule

//--- spp_ctrl.sv
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// [R1] per-cycle demand check steps duty up/down
// [R2] low flag sampled: negative raises, positive lowers
// [R3] high flag ends on-period at once
// [R4] high flag by foldback delay enters foldback
// [R5] high flag ignored during blanking after turn-on
// [R6] four consecutive desat cycles enter foldback
// [R7] over-temperature holds drive off until cleared
// [R8] thermal inhibit stays active; undervolt sleeps
// [R9] wake level restarts, hiccup repeats if hot
// [R10] stopped below undervolt until wake level
// [R11] proportional drive rises above collector reference
// [R12] normal on-time three quarters of resonance
// [R13] foldback shortens duty, then goes burst
// [R14] burst at max, then normal or foldback
// [R15] sleep to start-up sets standby mode
// [R16] sample and blank delays counted from turn-on
module spp_ctrl
    import spp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // comparator flags from the analog front end
    input wire spp_sense_t sense,
    // base drive pin group
    output spp_drive_t drive,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // interrupt
    output logic irq
);
    typedef enum logic [1:0] {SPP_P_OFF, SPP_P_ON} spp_phase_t;

    typedef struct packed {
        spp_supply_t supply;
        spp_mode_t mode;
        spp_phase_t phase;
        logic thermal_hold;
        logic [9:0] timer;
        logic [9:0] on_target;
        logic [9:0] off_target;
        logic [9:0] res_count;
        logic [9:0] res_period;
        logic [2:0] desat_count;
        logic [7:0] mode_cycles;
        logic high_seen;
        logic overload_hit;
        logic low_negative;
        logic res_prev;
        logic [3:0] pbd_level;
        logic [3:0] events;
    } spp_state_t;

    spp_state_t st_q; // all control state
    spp_state_t st_d; // next value
    spp_sense_t s; // synchronised flags
    logic drive_enable; // software enable
    logic [31:0] state_word; // readable state

    // comparator flags are asynchronous, so two flops first
    spp_sync u_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .raw(sense),
        .synced(s)
    );

    spp_regs u_regs (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .events(st_q.events),
        .state_word(state_word),
        .drive_enable(drive_enable),
        .irq(irq)
    );

    // three quarters of a period, floor at the minimum on-time
    function automatic logic [9:0] spp_three_quarter(input logic [9:0] p);
        logic [9:0] q;
        q = (p >> 1) + (p >> 2);
        return (q < SPP_MIN_ON_CYC) ? SPP_MIN_ON_CYC : q;
    endfunction

    // saturating step helpers
    function automatic logic [9:0] spp_step_up(input logic [9:0] v, input logic [9:0] lim);
        return (v + SPP_STEP_CYC > lim) ? lim : v + SPP_STEP_CYC;
    endfunction

    function automatic logic [9:0] spp_step_down(input logic [9:0] v, input logic [9:0] lim);
        return (v < lim + SPP_STEP_CYC) ? lim : v - SPP_STEP_CYC;
    endfunction

    assign state_word = {16'h0, st_q.pbd_level, st_q.desat_count, st_q.thermal_hold,
                         2'h0, st_q.supply, 1'b0, st_q.mode};

    // next-state logic for supply, mode and switching cycle
    always_comb begin
        logic [9:0] max_on; // on-time ceiling from resonance
        logic end_cycle; // one conversion cycle finished
        logic hp; // high flag past blanking
        st_d = st_q;
        st_d.events = '0;
        end_cycle = 1'b0;
        max_on = spp_three_quarter(st_q.res_period);
        hp = 1'b0;
        // resonance measurement: count off-time cycles since turn-off or the last edge
        st_d.res_prev = s.resonance_edge;
        if (st_q.phase == SPP_P_OFF) begin
            if (s.resonance_edge && !st_q.res_prev) begin
                st_d.res_period = st_q.res_count;
                st_d.res_count = '0;
            end else if (st_q.res_count != 10'h3ff) begin
                st_d.res_count = st_q.res_count + 10'h001;
            end
        end else begin
            st_d.res_count = '0;
        end
        // [R7] thermal hold with hysteresis release
        if (s.over_temperature) begin
            st_d.thermal_hold = 1'b1;
            if (!st_q.thermal_hold) begin
                st_d.events[SPP_EV_THERMAL] = 1'b1;
            end
        end else if (s.temp_cleared) begin
            st_d.thermal_hold = 1'b0;
        end
        unique case (st_q.supply)
            SPP_S_SLEEP: begin
                st_d.phase = SPP_P_OFF;
                st_d.timer = '0;
                // [R9] wake restarts from a clean state
                if (s.wake) begin
                    st_d.supply = SPP_S_ACTIVE;
                    // [R15] start-up mode standby
                    st_d.mode = SPP_M_STANDBY;
                    st_d.on_target = SPP_MIN_ON_CYC;
                    st_d.off_target = SPP_MAX_OFF_CYC;
                    st_d.res_period = SPP_DEFAULT_RES_CYC;
                    st_d.desat_count = '0;
                    st_d.mode_cycles = '0;
                end
            end
            SPP_S_ACTIVE: begin
                // [R8] thermal hold stays active; undervolt alone sleeps
                if (s.undervolt) begin
                    // [R10] stop below undervolt
                    st_d.supply = SPP_S_SLEEP;
                    st_d.phase = SPP_P_OFF;
                    st_d.events[SPP_EV_SLEEP] = 1'b1;
                end else if (st_q.phase == SPP_P_ON) begin
                    st_d.timer = st_q.timer + 10'h001;
                    // [R5] blanking window
                    hp = s.high_current_flag && st_q.timer >= SPP_BLANK_CYC;
                    if (hp && st_q.timer <= SPP_FOLDBACK_CYC) begin
                        // [R4] flag within the foldback delay
                        st_d.high_seen = 1'b1;
                    end
                    // [R2] [R16] low flag sample point
                    if (st_q.timer == SPP_LOW_SAMPLE_CYC) begin
                        st_d.low_negative = s.low_current_flag;
                    end
                    // [R3] overload ends the on-period now
                    if (hp || st_q.timer + 10'h001 >= st_q.on_target || st_q.thermal_hold) begin
                        st_d.overload_hit = hp;
                        // [R2] short pulses sample at their end, else demand is never seen
                        if (st_q.timer < SPP_LOW_SAMPLE_CYC) begin
                            st_d.low_negative = s.low_current_flag;
                        end
                        st_d.phase = SPP_P_OFF;
                        st_d.timer = '0;
                        // [R6] desat checked at end of on-time
                        if (s.collector_desat_guard) begin
                            st_d.desat_count = (st_q.desat_count == SPP_DESAT_LIMIT) ?
                                st_q.desat_count : st_q.desat_count + 3'h1;
                        end else begin
                            st_d.desat_count = '0;
                        end
                    end
                end else begin
                    st_d.timer = st_q.timer + 10'h001;
                    if (st_q.timer + 10'h001 >= st_q.off_target) begin
                        end_cycle = 1'b1;
                    end
                end
            end
            default: st_d.supply = SPP_S_SLEEP;
        endcase
        // [R1] once per conversion cycle, evaluate demand and mode
        if (end_cycle) begin
            st_d.timer = '0;
            st_d.high_seen = 1'b0;
            st_d.overload_hit = 1'b0;
            st_d.mode_cycles = st_q.mode_cycles + 8'h01;
            if (st_q.overload_hit) begin
                st_d.events[SPP_EV_OVERLOAD] = 1'b1;
            end
            unique case (st_q.mode)
                SPP_M_STANDBY, SPP_M_NORMAL, SPP_M_OVERLOAD: begin
                    // [R2] negative sense raises duty, positive lowers
                    if (st_q.low_negative) begin
                        if (st_q.off_target > st_q.res_period) begin
                            st_d.off_target = spp_step_down(st_q.off_target, st_q.res_period);
                        end else begin
                            st_d.on_target = spp_step_up(st_q.on_target, max_on);
                        end
                    end else if (st_q.on_target > SPP_MIN_ON_CYC) begin
                        st_d.on_target = spp_step_down(st_q.on_target, SPP_MIN_ON_CYC);
                    end else begin
                        st_d.off_target = spp_step_up(st_q.off_target, SPP_MAX_OFF_CYC);
                    end
                    // judge the new targets, so normal can step back down to standby
                    st_d.mode = st_q.overload_hit ? SPP_M_OVERLOAD :
                        (st_d.on_target >= max_on && st_d.off_target <= st_q.res_period) ?
                        SPP_M_NORMAL : SPP_M_STANDBY;
                    // [R12] full-duty on-time tracks the resonance
                    if (st_d.mode == SPP_M_NORMAL) begin
                        st_d.on_target = max_on;
                        st_d.off_target = st_q.res_period;
                    end
                end
                SPP_M_FOLDBACK: begin
                    // [R13] fixed stay, then power burst
                    if (st_q.mode_cycles + 8'h01 >= SPP_FOLDBACK_CYCLES) begin
                        st_d.mode = SPP_M_BURST;
                        st_d.mode_cycles = '0;
                        st_d.on_target = max_on;
                        st_d.off_target = st_q.res_period;
                    end
                end
                SPP_M_BURST: begin
                    // [R14] end of burst decides normal or foldback
                    if (st_q.mode_cycles + 8'h01 >= SPP_BURST_CYCLES) begin
                        st_d.mode = SPP_M_NORMAL;
                        st_d.mode_cycles = '0;
                    end
                end
                default: st_d.mode = SPP_M_STANDBY;
            endcase
            // [R4] [R6] heavy overload or desat forces foldback
            if (st_q.high_seen || st_q.desat_count >= SPP_DESAT_LIMIT) begin
                if (st_q.mode != SPP_M_FOLDBACK) begin
                    st_d.events[SPP_EV_FOLDBACK] = 1'b1;
                end
                // [R13] foldback shortens on and stretches off
                st_d.mode = SPP_M_FOLDBACK;
                st_d.mode_cycles = '0;
                st_d.on_target = SPP_MIN_ON_CYC;
                st_d.off_target = SPP_MAX_OFF_CYC;
                st_d.desat_count = '0;
            end
            // start next on-period unless held off
            if (!st_q.thermal_hold && drive_enable) begin
                st_d.phase = SPP_P_ON;
            end
        end
        // [R11] proportional drive tracks collector above reference
        if (st_q.phase == SPP_P_ON && st_q.timer >= SPP_FORCE_ON_CYC) begin
            if (s.collector_above_ref && st_q.pbd_level != SPP_PBD_MAX) begin
                st_d.pbd_level = st_q.pbd_level + 4'h1;
            end
        end else begin
            st_d.pbd_level = '0;
        end
    end

    // single state register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '{supply: SPP_S_SLEEP, mode: SPP_M_STANDBY, phase: SPP_P_OFF,
                      res_period: SPP_DEFAULT_RES_CYC, on_target: SPP_MIN_ON_CYC,
                      off_target: SPP_MAX_OFF_CYC, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    // drive outputs straight from state flops; thermal hold gates at once
    assign drive.base_drive_out = st_q.phase == SPP_P_ON && !st_q.thermal_hold;
    assign drive.force_on_pulse = drive.base_drive_out && st_q.timer < SPP_FORCE_ON_CYC;
    assign drive.proportional_drive_phase = drive.base_drive_out && !drive.force_on_pulse;
    assign drive.pbd_level = st_q.pbd_level;
endmodule

//--- spp_ctrl_checker.sv
`timescale 1ns/1ps
// port-level watcher for the power controller
module spp_ctrl_checker
    import spp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // pins
    input wire spp_sense_t sense,
    input wire spp_drive_t drive,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    logic [9:0] on_q; // cycles since turn-on
    logic [9:0] on_d; // next on count
    // count the on-period, zero while off
    always_comb begin
        on_d = drive.base_drive_out ? on_q + 10'h001 : 10'h000;
    end
    // register the count
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            on_q <= 10'h000;
        end else begin
            on_q <= on_d;
        end
    end

    // switch turn-on seen at the pin
    sequence turn_on;
        $rose(drive.base_drive_out);
    endsequence
    // overcurrent well past the blanking window
    sequence late_over;
        drive.base_drive_out && on_q >= 10'h006 && sense.high_current_flag;
    endsequence

    blank_hold_a: assert property (turn_on |-> drive.base_drive_out[*4])
        else $error("on-period shorter than blanking");
    high_cut_a: assert property (late_over |-> ##[1:5] !drive.base_drive_out)
        else $error("overcurrent did not end the on-period");
    force_on_start_a: assert property (turn_on |-> drive.force_on_pulse)
        else $error("turn-on without force-on pulse");
    pbd_after_fon_a: assert property (
        $rose(drive.proportional_drive_phase) |-> on_q == 10'h008 && $past(drive.force_on_pulse))
        else $error("proportional phase started at wrong time");
    pbd_idle_fon_a: assert property (
        drive.force_on_pulse |-> drive.pbd_level == 4'h0)
        else $error("proportional drive level during force-on");
    undervolt_stop_a: assert property (sense.undervolt[*5] |-> !drive.base_drive_out)
        else $error("drive during undervoltage");
    thermal_hold_a: assert property (sense.over_temperature[*5] |-> !drive.base_drive_out)
        else $error("drive while over temperature");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    mask_clear_a: assert property (
        (reg_wr && reg_addr == 4'hc && reg_wdata[3:0] == 4'h0) |=> !irq)
        else $error("interrupt with empty mask");
endmodule

bind spp_ctrl spp_ctrl_checker u_chk (.sys_clk(sys_clk), .rstn(rstn), .sense(sense),
    .drive(drive), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

//--- spp_switch_model.sv
`timescale 1ns/1ps
// behavioural primary switch with its sense network
module spp_switch_model
    import spp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // base drive from the block
    input wire spp_drive_t drive,
    // scenario knobs
    input wire logic overload,
    input wire logic desat,
    input wire logic demand,
    // sense levels back to the block
    output logic low_flag,
    output logic high_flag,
    output logic desat_flag,
    output logic above_ref,
    output logic res_edge
);
    logic [9:0] on_q; // conducting cycles
    logic [9:0] off_q; // cycles since switch opened
    // conduction and resonance timers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            on_q <= 10'h000;
            off_q <= 10'h000;
        end else begin
            on_q <= drive.base_drive_out ? on_q + 10'h001 : 10'h000;
            off_q <= drive.base_drive_out ? 10'h000 : off_q + 10'h001;
        end
    end
    // current ramps, so overload crosses only after some cycles
    assign high_flag = overload && drive.base_drive_out && on_q >= 10'h008;
    // sense idles positive when no current flows
    assign low_flag = drive.base_drive_out && demand;
    assign desat_flag = desat && drive.base_drive_out;
    // collector wanders about the reference while on
    assign above_ref = drive.base_drive_out && on_q[2];
    // ring boundary 60 cycles into the off-period
    assign res_edge = !drive.base_drive_out && off_q == 10'h03c;
endmodule

//--- switch_power_protection_ctrl_bench.sv
`timescale 1ns/1ps
// self-checking bench for the power controller
module switch_power_protection_ctrl_bench;
    import spp_pkg::*;
    logic sys_clk, rstn, reg_wr, reg_rd, irq; // clock, reset, strobes
    logic [3:0] reg_addr; // register address
    logic [31:0] reg_wdata, reg_rdata, d; // bus data
    logic overload, desat, demand, over_temp, temp_ok, undervolt, wake; // knobs
    logic low_flag, high_flag, desat_flag, above_ref, res_edge; // model flags
    spp_sense_t sense; // flag bundle
    spp_drive_t drive; // drive pins
    int err_total, checks, len, prev, hi; // tallies
    assign sense = {low_flag, high_flag, desat_flag, above_ref, over_temp, temp_ok,
        undervolt, wake, res_edge};
    spp_ctrl u_dut (.sys_clk(sys_clk), .rstn(rstn), .sense(sense), .drive(drive),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));
    spp_switch_model u_sw (.sys_clk(sys_clk), .rstn(rstn), .drive(drive),
        .overload(overload), .desat(desat), .demand(demand), .low_flag(low_flag),
        .high_flag(high_flag), .desat_flag(desat_flag), .above_ref(above_ref),
        .res_edge(res_edge));
    // free-running 100 MHz clock
    always #5 sys_clk = ~sys_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // wait for a turn-on, return its length in cycles
    task automatic next_pulse();
        int n;
        n = 0;
        len = 0;
        while (drive.base_drive_out !== 1'b1 && n < 1200) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        while (drive.base_drive_out === 1'b1 && len < 1200) begin
            @(posedge sys_clk);
            #1;
            len++;
        end
    endtask
    // count drive cycles over a span
    task automatic quiet(input int n);
        hi = 0;
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            hi += (drive.base_drive_out !== 1'b0);
        end
    endtask
    task automatic t_reset_regs();
        reg_read(4'h0);
        check(d, 32'h1);
        reg_read(4'h4);
        check({26'h0, d[5:0]}, 32'h0);
        reg_read(4'h8);
        check(d, 32'h0);
        reg_read(4'hc);
        check(d, 32'h0);
        reg_read(4'h2);
        check(d, 32'h0);
    endtask
    task automatic t_wake();
        wake <= 1'b1;
        next_pulse();
        check({31'h0, len >= 4}, 32'h1);
        wake <= 1'b0;
        reg_read(4'h4);
        check({26'h0, d[5:0]}, 32'h10);
    endtask
    // demand grows the on-time until it settles at its ceiling
    task automatic t_grow();
        int n;
        n = 0;
        demand <= 1'b1;
        next_pulse();
        // off-time shrinks in small steps first, so over two hundred pulses pass
        while (len < 46 && n < 300) begin
            next_pulse();
            n++;
        end
        prev = len;
        check({31'h0, len > 19}, 32'h1);
        check({31'h0, len >= 44 && len <= 46}, 32'h1);
        demand <= 1'b0;
        repeat (3) next_pulse();
        check({31'h0, len < prev}, 32'h1);
    endtask
    task automatic t_desat();
        desat <= 1'b1;
        repeat (3) next_pulse();
        reg_read(4'h4);
        check({31'h0, d[2:0] == 3'h3}, 32'h0);
        check({29'h0, d[11:9]}, 32'h3);
        next_pulse();
        // the mode decision waits for the end of the long off-time
        repeat (500) @(posedge sys_clk);
        reg_read(4'h4);
        check({29'h0, d[2:0]}, 32'h3);
        desat <= 1'b0;
    endtask
    task automatic t_thermal();
        over_temp <= 1'b1;
        repeat (10) @(posedge sys_clk);
        quiet(1200);
        check(hi, 32'h0);
        reg_read(4'h4);
        check({23'h0, d[8], 2'h0, d[5:4], 4'h0}, 32'h110);
        undervolt <= 1'b1;
        repeat (10) @(posedge sys_clk);
        reg_read(4'h4);
        check({30'h0, d[5:4]}, 32'h0);
        reg_read(4'h8);
        check({31'h0, d[SPP_EV_SLEEP]}, 32'h1);
        over_temp <= 1'b0;
        temp_ok <= 1'b1;
        undervolt <= 1'b0;
        quiet(1200);
        check(hi, 32'h0);
        t_wake();
    endtask
    task automatic t_overload();
        reg_write(4'h8, 32'hf);
        reg_write(4'hc, 32'h2);
        check({31'h0, irq}, 32'h0);
        overload <= 1'b1;
        next_pulse();
        check({31'h0, len >= 8 && len <= 12}, 32'h1);
        repeat (70) @(posedge sys_clk);
        reg_read(4'h4);
        check({29'h0, d[2:0]}, 32'h3);
        check({31'h0, irq}, 32'h1);
        reg_write(4'h8, 32'h2);
        @(posedge sys_clk);
        check({31'h0, irq}, 32'h0);
        reg_write(4'hc, 32'h0);
        overload <= 1'b0;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // watchdog against a hung sequence
    initial begin
        repeat (95000) @(posedge sys_clk);
        err_total++;
        complete_run();
    end
    // main sequence
    initial begin
        {sys_clk, rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {overload, desat, demand, over_temp, temp_ok, undervolt, wake} = '0;
        err_total = 0;
        checks = 0;
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset_regs();
        t_wake();
        t_grow();
        t_overload();
        t_thermal();
        t_desat();
        complete_run();
    end
endmodule
